// ### common/alu_pkg.sv
// Shared constants, types and helpers of the accumulator logic unit
package alu_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the AXI4-Lite slave)
  // ----------------------------------------------------------------
  localparam logic [7:0] ALU_OFS_ACC = 8'h00;
  localparam logic [7:0] ALU_OFS_OPA = 8'h04;
  localparam logic [7:0] ALU_OFS_OPB = 8'h08;
  localparam logic [7:0] ALU_OFS_RUN_START = 8'h0c;
  localparam logic [7:0] ALU_OFS_RUN_COUNT = 8'h10;
  localparam logic [7:0] ALU_OFS_CMD = 8'h14;
  localparam logic [7:0] ALU_OFS_STACK = 8'h18;
  localparam logic [7:0] ALU_OFS_FLAGS = 8'h1c;
  localparam logic [7:0] ALU_OFS_IRQ_STS = 8'h20;
  localparam logic [7:0] ALU_OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] ALU_OFS_STACK_DEPTH = 8'h28;
  localparam logic [7:0] ALU_OFS_BITMEM = 8'h80;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ALU_FLAG_ZERO_BIT = 0;
  localparam int ALU_FLAG_NEG_BIT = 1;
  localparam int ALU_FLAG_ERR_BIT = 2;
  localparam int ALU_IRQ_DONE_BIT = 0;
  localparam int ALU_IRQ_ERR_BIT = 1;
  localparam logic [31:0] ALU_ACC_RST = 32'h0000_0000;
  localparam logic [31:0] ALU_OPND_RST = 32'h0000_0000;
  localparam logic [9:0] ALU_START_RST = 10'h000;
  localparam logic [5:0] ALU_COUNT_RST = 6'h01;
  localparam logic [1:0] ALU_IRQ_MASK_RST = 2'h0;

  // ----------------------------------------------------------------
  // Sizes and limits
  // ----------------------------------------------------------------
  localparam int ALU_STACK_LEVELS = 8;
  localparam int ALU_BITMEM_WORDS = 32;
  localparam logic [5:0] ALU_RUN_MIN = 6'h01;
  localparam logic [5:0] ALU_RUN_MAX = 6'h20;
  localparam logic [1:0] ALU_RESP_OKAY = 2'h0;
  localparam logic [1:0] ALU_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Operation codes written to the command register
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ALU_OP_NONE = 3'h0,
    ALU_OP_OR_WORD = 3'h1,
    ALU_OP_OR_DOUBLE_WORD = 3'h2,
    ALU_OP_OR_BIT_RUN = 3'h3,
    ALU_OP_OR_STACK_TOP = 3'h4,
    ALU_OP_AND_BIT_RUN = 3'h5,
    ALU_OP_AND_STACK_TOP = 3'h6
  } alu_op_type;

  // Discrete run selection
  typedef struct packed
  {
    logic [9:0] start;
    logic [5:0] count;
  } alu_run_sel_type;

  // Result flags
  typedef struct packed
  {
    logic result_negative_flag;
    logic result_zero_flag;
  } alu_flags_type;

  // Merge a write word into a register under AXI byte strobes
  function automatic logic [31:0] alu_apply_strb(input logic [31:0] old_val,
                                                 input logic [31:0] new_val,
                                                 input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

// ### src/alu_bit_run.sv
// Discrete bit memory with a gather port for runs of 1 to 32 bits
`timescale 1ns/1ns
module alu_bit_run
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  input wire logic [4:0] rd_idx,
  output logic [31:0] rd_data,
  input wire alu_pkg::alu_run_sel_type sel,
  output logic [31:0] run
);
  import alu_pkg::*;

  typedef struct packed
  {
    logic [ALU_BITMEM_WORDS-1:0][31:0] mem;
  } alu_bitmem_state_type;

  alu_bitmem_state_type s_q;
  alu_bitmem_state_type s_d;
  logic [4:0] lo_idx;
  logic [4:0] hi_idx;
  logic [63:0] window;
  logic [31:0] mask;

  // ----------------------------------------------------------------
  // Word writes from the register bus
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    if (wr_en)
    begin
      s_d.mem[wr_idx] = alu_apply_strb(s_q.mem[wr_idx], wr_data, wr_strb);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Gather: start bit lands on bit 0, later bits climb upward
  // ----------------------------------------------------------------
  always_comb
  begin
    lo_idx = sel.start[9:5];
    hi_idx = lo_idx + 5'h01; // Wraps at the top of memory
    window = {s_q.mem[hi_idx], s_q.mem[lo_idx]} >> sel.start[4:0];
    if (sel.count >= ALU_RUN_MAX)
    begin
      mask = 32'hffff_ffff;
    end
    else
    begin
      mask = ~(32'hffff_ffff << sel.count[4:0]);
    end
    run = window[31:0] & mask;
    rd_data = s_q.mem[rd_idx];
  end

endmodule

// ### src/alu_stack.sv
// Accumulator stack: push from software, pop moves every level up
`timescale 1ns/1ns
module alu_stack
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic push,
  input wire logic [31:0] push_data,
  input wire logic pop,
  output logic [31:0] top,
  output logic [3:0] depth
);
  import alu_pkg::*;

  typedef struct packed
  {
    logic [ALU_STACK_LEVELS-1:0][31:0] lvl;
    logic [3:0] depth;
  } alu_stack_state_type;

  alu_stack_state_type s_q;
  alu_stack_state_type s_d;

  // ----------------------------------------------------------------
  // Level 0 is the top; a push when full drops the bottom level
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    if (pop && s_q.depth != 4'h0)
    begin
      for (int i = 0; i < ALU_STACK_LEVELS - 1; i++)
      begin
        s_d.lvl[i] = s_q.lvl[i+1];
      end
      s_d.lvl[ALU_STACK_LEVELS-1] = '0;
      s_d.depth = s_q.depth - 4'h1;
    end
    else if (push)
    begin
      for (int i = ALU_STACK_LEVELS - 1; i > 0; i--)
      begin
        s_d.lvl[i] = s_q.lvl[i-1];
      end
      s_d.lvl[0] = push_data;
      if (s_q.depth != 4'(ALU_STACK_LEVELS))
      begin
        s_d.depth = s_q.depth + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign top = s_q.lvl[0];
  assign depth = s_q.depth;

endmodule

// ### src/alu_top.sv
// Accumulator logic unit with AXI4-Lite register access
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Function
// - AND of the accumulator with a run of 1 to 32 discrete bits.
// - A run is given by a start bit address and a count of 1 to 32.
// - The zero flag follows whether the new accumulator is zero.
// - Double, run and stack forms set the negative flag from bit 31.
// - A flag holds until the next operation that writes that flag.
// - AND with stack And_stack_top all 32 bits with the top stack level.
// - A stack form drops the top level and moves the rest up one.
// - Single-word OR merges one 16-bit word into the low accumulator half.
// - Single-word OR writes the zero flag only, never the negative flag.
// - Double OR ORs all 32 bits with a two-word or constant operand.
// - OR of the accumulator with a run of 1 to 32 discrete bits.
// - OR with stack ORs all 32 bits with the top stack level.
// ------------------------------------------------------------------
module alu_top
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  import alu_pkg::*;

  typedef struct packed
  {
    logic [31:0] acc;
    logic [31:0] opa;
    logic [31:0] opb;
    alu_run_sel_type run_sel;
    alu_flags_type flags;
    logic err;
    logic [1:0] irq_sts;
    logic [1:0] irq_mask;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } alu_top_state_type;

  alu_top_state_type s_q;
  alu_top_state_type s_d;

  logic wr_go;
  logic rd_go;
  logic wr_bitmem;
  logic rd_bitmem;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [31:0] bit_rd_data;
  logic [31:0] run_bits;
  logic [31:0] stack_top;
  logic [3:0] stack_depth;
  logic stack_push;
  logic stack_pop;
  logic [31:0] res;
  logic run_ok;
  logic op_start;
  logic op_done;
  logic op_err;
  logic upd_neg;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  alu_op_type op;

  // ----------------------------------------------------------------
  // Leaf blocks
  // ----------------------------------------------------------------
  alu_bit_run u_bit_run
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wr_en(wr_bitmem),
    .wr_idx(wa[6:2]),
    .wr_data(s_axi_wdata),
    .wr_strb(s_axi_wstrb),
    .rd_idx(ra[6:2]),
    .rd_data(bit_rd_data),
    .sel(s_q.run_sel),
    .run(run_bits)
  );

  alu_stack u_stack
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .push(stack_push),
    .push_data(s_axi_wdata),
    .pop(stack_pop),
    .top(stack_top),
    .depth(stack_depth)
  );

  // ----------------------------------------------------------------
  // Bus handshakes: a write is taken only with address and data together
  // ----------------------------------------------------------------
  assign wa = {s_axi_awaddr[7:2], 2'b00};
  assign ra = {s_axi_araddr[7:2], 2'b00};
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
  assign rd_go = s_axi_arvalid && !s_q.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = !s_q.rvalid;
  assign wr_bitmem = wr_go && wa[7];
  assign rd_bitmem = ra[7];
  assign stack_push = wr_go && wa == ALU_OFS_STACK;
  assign op_start = wr_go && wa == ALU_OFS_CMD;
  assign op = alu_op_type'(s_axi_wdata[2:0]);
  assign run_ok = s_q.run_sel.count >= ALU_RUN_MIN && s_q.run_sel.count <= ALU_RUN_MAX;

  // ----------------------------------------------------------------
  // Datapath: the command write itself runs the operation
  // ----------------------------------------------------------------
  always_comb
  begin
    res = s_q.acc;
    upd_neg = 1'b1;
    op_done = 1'b0;
    op_err = 1'b0;
    stack_pop = 1'b0;
    if (op_start)
    begin
      case (op)
        ALU_OP_OR_WORD:
        begin
          res = s_q.acc | {16'h0000, s_q.opa[15:0]};
          upd_neg = 1'b0;
          op_done = 1'b1;
        end
        ALU_OP_OR_DOUBLE_WORD:
        begin
          res = s_q.acc | s_q.opa;
          op_done = 1'b1;
        end
        ALU_OP_OR_BIT_RUN:
        begin
          res = s_q.acc | run_bits;
          op_done = run_ok;
          op_err = !run_ok;
        end
        ALU_OP_AND_BIT_RUN:
        begin
          res = s_q.acc & run_bits;
          op_done = run_ok;
          op_err = !run_ok;
        end
        ALU_OP_OR_STACK_TOP:
        begin
          res = s_q.acc | stack_top;
          op_done = stack_depth != 4'h0;
          op_err = stack_depth == 4'h0;
          stack_pop = op_done;
        end
        ALU_OP_AND_STACK_TOP:
        begin
          res = s_q.acc & stack_top;
          op_done = stack_depth != 4'h0;
          op_err = stack_depth == 4'h0;
          stack_pop = op_done;
        end
        default:
        begin
          op_err = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file, flags and interrupt status
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    irq_set = {op_err, op_done};
    irq_clr = 2'b00;
    // Register writes
    if (wr_go)
    begin
      s_d.bvalid = 1'b1;
      s_d.bresp = ALU_RESP_OKAY;
      case (wa)
        ALU_OFS_ACC: s_d.acc = alu_apply_strb(s_q.acc, s_axi_wdata, s_axi_wstrb);
        ALU_OFS_OPA: s_d.opa = alu_apply_strb(s_q.opa, s_axi_wdata, s_axi_wstrb);
        ALU_OFS_OPB: s_d.opb = alu_apply_strb(s_q.opb, s_axi_wdata, s_axi_wstrb);
        ALU_OFS_RUN_START: s_d.run_sel.start = s_axi_wdata[9:0];
        ALU_OFS_RUN_COUNT: s_d.run_sel.count = s_axi_wdata[5:0];
        ALU_OFS_IRQ_MASK: s_d.irq_mask = s_axi_wdata[1:0];
        ALU_OFS_CMD, ALU_OFS_STACK:
        begin
          s_d.bresp = ALU_RESP_OKAY;
        end
        default:
        begin
          if (!wa[7])
          begin
            s_d.bresp = ALU_RESP_SLVERR;
          end
        end
      endcase
    end
    else if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    // Operation results; flags change only on operations that write them
    if (op_done)
    begin
      s_d.acc = res;
      s_d.flags.result_zero_flag = res == 32'h0000_0000;
      if (upd_neg)
      begin
        s_d.flags.result_negative_flag = res[31];
      end
      s_d.err = 1'b0;
    end
    if (op_err)
    begin
      s_d.err = 1'b1; // Accumulator and flags left as they were
    end
    // Register reads
    if (rd_go)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = ALU_RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      if (rd_bitmem)
      begin
        s_d.rdata = bit_rd_data;
      end
      else
      begin
        case (ra)
          ALU_OFS_ACC: s_d.rdata = s_q.acc;
          ALU_OFS_OPA: s_d.rdata = s_q.opa;
          ALU_OFS_OPB: s_d.rdata = s_q.opb;
          ALU_OFS_RUN_START: s_d.rdata = {22'h000000, s_q.run_sel.start};
          ALU_OFS_RUN_COUNT: s_d.rdata = {26'h0000000, s_q.run_sel.count};
          ALU_OFS_CMD: s_d.rdata = 32'h0000_0000;
          ALU_OFS_STACK: s_d.rdata = stack_top;
          ALU_OFS_FLAGS: s_d.rdata = {29'h00000000, s_q.err, s_q.flags};
          ALU_OFS_IRQ_STS:
          begin
            s_d.rdata = {30'h00000000, s_q.irq_sts};
            irq_clr = 2'b11; // Clear on read
          end
          ALU_OFS_IRQ_MASK: s_d.rdata = {30'h00000000, s_q.irq_mask};
          ALU_OFS_STACK_DEPTH: s_d.rdata = {28'h0000000, stack_depth};
          default: s_d.rresp = ALU_RESP_SLVERR;
        endcase
      end
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    // A new event beats a read clear in the same cycle
    s_d.irq_sts = (s_q.irq_sts & ~irq_clr) | irq_set;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.acc <= ALU_ACC_RST;
      s_q.opa <= ALU_OPND_RST;
      s_q.opb <= ALU_OPND_RST;
      s_q.run_sel.start <= ALU_START_RST;
      s_q.run_sel.count <= ALU_COUNT_RST;
      s_q.irq_mask <= ALU_IRQ_MASK_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;
  assign irq = |(s_q.irq_sts & s_q.irq_mask); // Level, high while unmasked bit set

endmodule

// ### verification/alu_top_props.sv
// Bus handshake and interrupt checks of the accumulator logic unit
`timescale 1ns/1ns
module alu_top_props
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  import alu_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Writes that may legally raise the interrupt line
  logic cmd_wr;
  logic mask_wr;
  assign cmd_wr = s_axi_awvalid && s_axi_awready && (s_axi_awaddr[7:2] == ALU_OFS_CMD[7:2]);
  assign mask_wr = s_axi_awvalid && s_axi_awready && (s_axi_awaddr[7:2] == ALU_OFS_IRQ_MASK[7:2]);
  // Handshake timing; a response must stand still until it is taken
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  chk_ready_rules: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid &&
    !s_axi_bvalid) && s_axi_wready == s_axi_awready && s_axi_arready == !s_axi_rvalid)
    else $error("ready wrong");
  // Unmapped places answer with an error and no data; the command register reads zero without error
  chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr inside
    {[8'h2c:8'h7f]} |=> s_axi_rresp == ALU_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_cmd_read_zero: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == ALU_OFS_CMD |=> s_axi_rdata == 32'h0 && s_axi_rresp == ALU_RESP_OKAY)
    else $error("command register not write-only");
  // Status only grows from operations, so irq can only rise after a command or mask write
  chk_irq_cause: assert property ($rose(irq) |-> $past(cmd_wr || mask_wr))
    else $error("interrupt without cause");
  cover property (cmd_wr);
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rresp == ALU_RESP_SLVERR);
endmodule
bind alu_top alu_top_props i_alu_top_props
(
  .clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq)
);

// ### verification/alu_seq_model.sv
// AXI4-Lite master standing in for the instruction sequencer
`timescale 1ns/1ns
module alu_seq_model
(
  input wire logic clk_sys,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Idle bus at time zero
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Each channel is released on its own ready, so either order of acceptance works
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_left;
    logic w_left;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    while (aw_left || w_left)
    begin
      @(posedge clk_sys);
      aw_left = aw_left && !s_axi_awready;
      w_left = w_left && !s_axi_wready;
      s_axi_awvalid <= aw_left;
      s_axi_wvalid <= w_left;
    end
    while (!s_axi_bvalid) @(posedge clk_sys);
    s_axi_bready <= 1'b0;
  endtask
  // Read: address until taken, rready until data seen
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk_sys);
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ### verification/accumulator_logic_unit_tb_top.sv
// Self-checking bench of the accumulator logic unit
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module accumulator_logic_unit_tb_top;
  import alu_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [33:0] notes[$];
  logic [31:0] stk[$];
  logic [31:0] acc, opa, mem[32];
  logic [31:0] rng = 32'hbef5;
  logic [9:0] start;
  logic [5:0] cnt;
  logic [2:0] flg;
  logic [1:0] sts;
  logic [9:0] st_t[6] = '{10'h000, 10'h021, 10'h3fc, 10'h155, 10'h3ff, 10'h010};
  logic [5:0] ct_t[6] = '{6'h01, 6'h07, 6'h20, 6'h1f, 6'h08, 6'h20};

  always #50 clk_sys = ~clk_sys;

  alu_top i_alu_top
  (
    .clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq)
  );
  alu_seq_model i_alu_seq_model
  (
    .clk_sys(clk_sys), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  function automatic logic [31:0] xorshift();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // Gather the selected run; the bit address wraps past the last discrete bit
  function automatic logic [31:0] run_of();
    logic [31:0] r;
    logic [9:0] b;
    r = 32'h0;
    for (int i = 0; i < 32; i++)
    begin
      b = start + 10'(i);
      if (i < cnt) r[i] = mem[b[9:5]][b[4:0]];
    end
    return r;
  endfunction
  task automatic close_out();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Every bus call leaves its expected answer in the queue
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] rsp = ALU_RESP_OKAY);
    notes.push_back({rsp, 32'h0});
    i_alu_seq_model.wr(a, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] rsp = ALU_RESP_OKAY);
    notes.push_back({rsp, d});
    i_alu_seq_model.rd(a);
  endtask
  task automatic load(input logic [31:0] a_v, input logic [31:0] o_v);
    acc = a_v;
    opa = o_v;
    wr(ALU_OFS_ACC, a_v);
    wr(ALU_OFS_OPA, o_v);
  endtask
  task automatic push(input logic [31:0] v);
    stk.push_front(v);
    if (stk.size() > ALU_STACK_LEVELS) void'(stk.pop_back());
    wr(ALU_OFS_STACK, v);
  endtask
  // Reference result, then the flags are read before any later operation can move them
  task automatic do_op(input logic [2:0] code);
    logic [31:0] r;
    logic ok;
    ok = 1'b1;
    r = acc;
    case (code)
      3'h1: r = acc | {16'h0, opa[15:0]};
      3'h2: r = acc | opa;
      3'h3, 3'h5: if (cnt == 0 || cnt > 32) ok = 1'b0;
        else r = code[1] ? acc | run_of() : acc & run_of();
      3'h4, 3'h6: if (stk.size() == 0) ok = 1'b0;
        else r = code[1] ? acc & stk.pop_front() : acc | stk.pop_front();
      default: ok = 1'b0;
    endcase
    if (ok) {acc, flg[0], flg[2], sts[0]} = {r, r == 32'h0, 1'b0, 1'b1};
    if (ok && code != 3'h1) flg[1] = r[31];
    if (!ok) {flg[2], sts[1]} = 2'b11;
    wr(ALU_OFS_CMD, {29'h0, code});
    rd(ALU_OFS_ACC, acc);
    rd(ALU_OFS_FLAGS, {29'h0, flg});
    rd(ALU_OFS_STACK_DEPTH, {28'h0, 4'(stk.size())});
  endtask

  // Take the oldest note whenever a response is handed over
  always @(posedge clk_sys)
  begin : mon
    logic [33:0] note;
    if (s_axi_bvalid && s_axi_bready)
    begin
      note = notes.pop_front();
      `CHK({s_axi_bresp, 32'h0}, note)
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      note = notes.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, note)
    end
  end
  // Whole run needs under a thousand cycles; the ceiling leaves ample margin
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      close_out();
    end
  end

  initial
  begin
    {acc, opa, start, cnt, flg, sts} = {64'h0, 10'h0, 6'h1, 3'h0, 2'h0};
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(ALU_OFS_RUN_COUNT, 32'h1);
    rd(ALU_OFS_IRQ_MASK, 32'h0);
    rd(ALU_OFS_CMD, 32'h0);
    rd(8'h40, 32'h0, ALU_RESP_SLVERR);
    wr(8'h44, xorshift(), ALU_RESP_SLVERR);
    $display("test reset_map done");
    load(32'h0, 32'h8000_0000);
    do_op(ALU_OP_OR_DOUBLE_WORD);
    wr(ALU_OFS_ACC, 32'h0);
    acc = 32'h0;
    rd(ALU_OFS_FLAGS, {29'h0, flg});
    load(32'h0, 32'hffff_0000);
    do_op(ALU_OP_OR_WORD);
    load(xorshift(), xorshift());
    do_op(ALU_OP_OR_WORD);
    repeat (4)
    begin
      load(xorshift(), xorshift());
      do_op(ALU_OP_OR_DOUBLE_WORD);
    end
    $display("test word_or done");
    for (int i = 0; i < 32; i++)
    begin
      mem[i] = xorshift();
      wr(ALU_OFS_BITMEM + 8'(i * 4), mem[i]);
    end
    for (int i = 0; i < 8; i++)
    begin
      {start, cnt} = (i < 6) ? {st_t[i], ct_t[i]} : {10'h3fe, 6'(i * 33 - 198)};
      wr(ALU_OFS_RUN_START, {22'h0, start});
      wr(ALU_OFS_RUN_COUNT, {26'h0, cnt});
      load(xorshift() | 32'h8000_0000, opa);
      do_op(i[0] ? ALU_OP_OR_BIT_RUN : ALU_OP_AND_BIT_RUN);
    end
    $display("test bit_run done");
    repeat (3) push(xorshift());
    rd(ALU_OFS_STACK, stk[0]);
    do_op(ALU_OP_AND_STACK_TOP);
    rd(ALU_OFS_STACK, stk[0]);
    do_op(ALU_OP_OR_STACK_TOP);
    do_op(ALU_OP_OR_STACK_TOP);
    do_op(ALU_OP_AND_STACK_TOP);
    repeat (9) push(xorshift());
    do_op(ALU_OP_AND_STACK_TOP);
    $display("test stack done");
    rd(ALU_OFS_IRQ_STS, {30'h0, sts});
    sts = 2'h0;
    wr(ALU_OFS_IRQ_MASK, 32'h1);
    do_op(ALU_OP_OR_DOUBLE_WORD);
    @(negedge clk_sys);
    `CHK(irq, 1'b1)
    rd(ALU_OFS_IRQ_STS, {30'h0, sts});
    sts = 2'h0;
    do_op(ALU_OP_NONE);
    do_op(3'h7);
    @(negedge clk_sys);
    `CHK(irq, 1'b0)
    wr(ALU_OFS_IRQ_MASK, 32'h2);
    @(negedge clk_sys);
    `CHK(irq, 1'b1)
    rd(ALU_OFS_IRQ_STS, {30'h0, sts});
    sts = 2'h0;
    @(negedge clk_sys);
    `CHK(irq, 1'b0)
    $display("test interrupt done");
    close_out();
  end
endmodule
